// ===== hw/tiofm_pkg.sv
// Purpose: Constants and types for the terminal function mapper
// Assumes: Parameter values in 0.1 % units, analog values in mV or uA
// Notes: Index 0 sits at the communication address, the rest at base+index
package tiofm_pkg;
  // ==========================================================
  // Parameter map
  localparam logic [15:0] OFF_COMM = 16'h600b;
  localparam logic [15:0] OFF_BASE = 16'h0100;
  localparam int NREG = 30;
  localparam logic [4:0] R_COMM = 5'h00;
  localparam logic [4:0] R_RLY1_DLY = 5'h01;
  localparam logic [4:0] R_RLY2_DLY = 5'h02;
  localparam logic [4:0] R_SPD_LV1 = 5'h03;
  localparam logic [4:0] R_SPD_LV2 = 5'h04;
  localparam logic [4:0] R_SPD_BAND = 5'h05;
  localparam logic [4:0] R_TQ_SGN = 5'h06;
  localparam logic [4:0] R_TQ_ABS = 5'h07;
  localparam logic [4:0] R_OL_LV = 5'h08;
  localparam logic [4:0] R_FLT_FN = 5'h09;
  localparam logic [4:0] R_AI1_RNG = 5'h0a;
  localparam logic [4:0] R_AI1_GAIN = 5'h0b;
  localparam logic [4:0] R_AI1_BIAS = 5'h0c;
  localparam logic [4:0] R_AI2_RNG = 5'h0d;
  localparam logic [4:0] R_AI2_GAIN = 5'h0e;
  localparam logic [4:0] R_AI2_BIAS = 5'h0f;
  localparam logic [4:0] R_AI1_FILT = 5'h10;
  localparam logic [4:0] R_AI2_FILT = 5'h11;
  localparam logic [4:0] R_AI_MIN = 5'h12;
  localparam logic [4:0] R_AO1_SRC = 5'h13;
  localparam logic [4:0] R_AO1_RNG = 5'h14;
  localparam logic [4:0] R_AO1_GAIN = 5'h15;
  localparam logic [4:0] R_AO1_BIAS = 5'h16;
  localparam logic [4:0] R_AO1_FILT = 5'h17;
  localparam logic [4:0] R_AO2_SRC = 5'h18;
  localparam logic [4:0] R_AO2_GAIN = 5'h19;
  localparam logic [4:0] R_AO2_BIAS = 5'h1a;
  localparam logic [4:0] R_AO2_FILT = 5'h1b;
  localparam logic [4:0] R_RLY1_FN = 5'h1c;
  localparam logic [4:0] R_RLY2_FN = 5'h1d;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_OL_LV = 16'h01f4;
  localparam logic [15:0] RST_FLT_FN = 16'h0011;
  localparam logic [15:0] RST_GAIN = 16'h03e8;
  localparam logic [15:0] RST_FILT = 16'h0064;
  localparam logic [15:0] RST_AI_MIN = 16'h0028;
  localparam logic [15:0] RST_AO1_SRC = 16'h0003;
  localparam logic [15:0] RST_RLY1_FN = 16'h0023;
  // ==========================================================
  // Function codes, ranges, scaling and timing
  localparam logic [15:0] FN_SPD_EQ1 = 16'h0002;
  localparam logic [15:0] FN_SPD_GE1 = 16'h0003;
  localparam logic [15:0] FN_SPD_LE1 = 16'h0004;
  localparam logic [15:0] FN_SPD_EQ2 = 16'h0005;
  localparam logic [15:0] FN_SPD_GE2 = 16'h0006;
  localparam logic [15:0] FN_SPD_LE2 = 16'h0007;
  localparam logic [15:0] FN_ARRIVE = 16'h0008;
  localparam logic [15:0] FN_TQ_SGN = 16'h0009;
  localparam logic [15:0] FN_TQ_ABS = 16'h000a;
  localparam logic [15:0] FN_OL = 16'h000c;
  localparam logic [15:0] FN_REV = 16'h000e;
  localparam logic [15:0] FN_RUN_NODC = 16'h0010;
  localparam logic [15:0] FN_FAULT = 16'h0011;
  localparam logic [15:0] FN_RUN = 16'h0023;
  localparam logic [15:0] FN_COMM = 16'h0024;
  localparam logic [15:0] FN_WATER = 16'h0025;
  localparam logic [15:0] FN_BRAKE = 16'h0028;
  localparam logic [1:0] RNG_VOLT = 2'h0;
  localparam logic [1:0] RNG_BIPOLAR = 2'h1;
  localparam logic [1:0] RNG_CURRENT = 2'h2;
  localparam int FULL_MV = 10000;
  localparam int LOOP_MA_LO = 4000;
  localparam int PCT_UNIT = 1000;
  localparam int BIAS_MV = 10;
  localparam int TICK_MS = 1;
  localparam int DELAY_UNIT_MS = 100;
  localparam int TICKS_PER_DELAY = DELAY_UNIT_MS / TICK_MS;
  // ==========================================================
  // Drive state sampled from the core
  typedef struct packed {
    logic running;
    logic dc_brake;
    logic fault;
    logic water_alarm;
    logic brake_ctrl;
    logic signed [15:0] set_speed;
    logic signed [15:0] out_speed;
    logic signed [15:0] out_freq;
    logic signed [15:0] out_current;
    logic signed [15:0] out_voltage;
    logic signed [15:0] dc_bus;
    logic signed [15:0] torque_cmd;
    logic signed [15:0] torque;
    logic signed [15:0] ain_three;
    logic signed [15:0] pulse_freq;
  } tiofm_drv_type;
endpackage

// ===== hw/tiofm_top.sv
// Purpose: Maps drive conditions onto relays and conditions analog terminals
// Assumes: TICK pulses once per sampling period, parameters written on PAR port
// Notes: Filters, analog outputs and relay delay counts advance on TICK; CE low freezes everything

// Contract
// - Code 35 on while running or DC braking
// - Code 36 follows communication register bit
// - Code 37 follows water shortage alarm
// - Code 40 mirrors brake control signal
// - Relays one and two switch on after configurable delay
// - Two speed detection levels, percent of max
// - Speed arrive uses configurable tolerance band
// - Signed and absolute torque thresholds
// - Overload pre-alarm threshold, default fifty percent
// - Fault relay code selectable, default fault
// - Input one voltage clamp or 4-20 mA
// - Input two unipolar or bipolar voltage
// - Input gain and bias, 100% is 10V
// - Input low-pass filter, default 0.1 s
// - Input below minimum level reads zero
// - Output source selected from twelve codes
// - Output one voltage or 4-20 mA
// - Output gain and bias both signed, result clipped at zero
// - Each source scaled to its full range
module tiofm_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic TICK,
  input wire tiofm_pkg::tiofm_drv_type DRV,
  input wire logic signed [15:0] AIN_ONE,
  input wire logic signed [15:0] AIN_TWO,
  input wire logic PAR_WE,
  input wire logic [15:0] PAR_ADDR,
  input wire logic [15:0] PAR_WDATA,
  output logic [15:0] PAR_RDATA,
  output logic RELAY_OUTPUT_ONE,
  output logic RELAY_OUTPUT_TWO,
  output logic FAULT_CHANGEOVER_RELAY,
  output logic signed [15:0] AIN_ONE_VAL,
  output logic signed [15:0] AIN_TWO_VAL,
  output logic [15:0] ANALOG_OUTPUT_ONE,
  output logic [15:0] ANALOG_OUTPUT_TWO
);
  // ==========================================================
  // Functions
  // Address to register index; unmapped gives valid low
  function automatic logic [5:0] fn_decode(input logic [15:0] a);
    logic [15:0] d;
    d = a - tiofm_pkg::OFF_BASE;
    if (a == tiofm_pkg::OFF_COMM) begin
      return {1'b1, tiofm_pkg::R_COMM};
    end
    if (a > tiofm_pkg::OFF_BASE && d < 16'(tiofm_pkg::NREG)) begin
      return {1'b1, d[4:0]};
    end
    return 6'h00;
  endfunction

  function automatic logic [15:0] fn_rst(input logic [4:0] i);
    unique case (i)
      tiofm_pkg::R_OL_LV: return tiofm_pkg::RST_OL_LV;
      tiofm_pkg::R_FLT_FN: return tiofm_pkg::RST_FLT_FN;
      tiofm_pkg::R_AI1_GAIN, tiofm_pkg::R_AI2_GAIN,
      tiofm_pkg::R_AO1_GAIN, tiofm_pkg::R_AO2_GAIN: return tiofm_pkg::RST_GAIN;
      tiofm_pkg::R_AI1_FILT, tiofm_pkg::R_AI2_FILT,
      tiofm_pkg::R_AO1_FILT, tiofm_pkg::R_AO2_FILT: return tiofm_pkg::RST_FILT;
      tiofm_pkg::R_AI_MIN: return tiofm_pkg::RST_AI_MIN;
      tiofm_pkg::R_AO1_SRC: return tiofm_pkg::RST_AO1_SRC;
      tiofm_pkg::R_RLY1_FN: return tiofm_pkg::RST_RLY1_FN;
      default: return tiofm_pkg::RST_ZERO;
    endcase
  endfunction

  function automatic logic signed [31:0] fn_abs(input logic signed [31:0] x);
    return (x < 0) ? -x : x;
  endfunction

  // Gain times signal plus bias, clipped to the range
  function automatic logic signed [31:0] fn_scale(input logic signed [31:0] x,
      input logic [15:0] g, input logic [15:0] b,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
    logic signed [47:0] t;
    t = 48'(x) * 48'($signed(g));
    t = t / 48'(tiofm_pkg::PCT_UNIT);
    t = t + 48'($signed(b)) * 48'(tiofm_pkg::BIAS_MV);
    if (t < 48'(lo)) begin
      return lo;
    end
    if (t > 48'(hi)) begin
      return hi;
    end
    return 32'(t);
  endfunction

  // One step of y += (x - y) / (tau + 1); tau in ticks
  function automatic logic signed [31:0] fn_filt(input logic signed [31:0] y,
      input logic signed [31:0] x, input logic [15:0] tau_ms);
    logic signed [31:0] k;
    k = 32'(tau_ms / 16'(tiofm_pkg::TICK_MS)) + 32'sd1;
    if (tau_ms == 16'h0000) begin
      return x;
    end
    return y + (x - y) / k;
  endfunction

  // Range handling and dead band of an analog input
  function automatic logic signed [31:0] fn_ain(input logic signed [15:0] raw,
      input logic [1:0] rng, input logic bip_ok, input logic [15:0] min);
    logic signed [31:0] v;
    v = 32'(raw);
    if (!bip_ok && rng == tiofm_pkg::RNG_CURRENT) begin
      v = ((v - tiofm_pkg::LOOP_MA_LO) * 5) / 8;
    end
    if (!(bip_ok && rng == tiofm_pkg::RNG_BIPOLAR) && v < 0) begin
      v = 0;
    end
    if (fn_abs(v) < 32'(min)) begin
      v = 0;
    end
    return v;
  endfunction

  // Output condition for a function code
  function automatic logic fn_cond(input logic [15:0] code,
      input tiofm_pkg::tiofm_drv_type d, input logic comm,
      input logic [15:0] lv1, input logic [15:0] lv2, input logic [15:0] band,
      input logic [15:0] tqs, input logic [15:0] tqa, input logic [15:0] ol);
    logic signed [15:0] s;
    s = d.out_speed;
    unique case (code)
      tiofm_pkg::FN_SPD_EQ1: return s == $signed(lv1);
      tiofm_pkg::FN_SPD_GE1: return s >= $signed(lv1);
      tiofm_pkg::FN_SPD_LE1: return s <= $signed(lv1);
      tiofm_pkg::FN_SPD_EQ2: return s == $signed(lv2);
      tiofm_pkg::FN_SPD_GE2: return s >= $signed(lv2);
      tiofm_pkg::FN_SPD_LE2: return s <= $signed(lv2);
      tiofm_pkg::FN_ARRIVE:
        return fn_abs(32'(s) - 32'(d.set_speed)) <= 32'(band);
      tiofm_pkg::FN_TQ_SGN: return d.torque >= $signed(tqs);
      tiofm_pkg::FN_TQ_ABS: return fn_abs(32'(d.torque)) >= 32'(tqa);
      tiofm_pkg::FN_OL: return d.out_current > $signed(ol);
      tiofm_pkg::FN_REV: return s < 0;
      tiofm_pkg::FN_RUN_NODC: return d.running && !d.dc_brake;
      tiofm_pkg::FN_FAULT: return d.fault;
      tiofm_pkg::FN_RUN: return d.running || d.dc_brake;
      tiofm_pkg::FN_COMM: return comm;
      tiofm_pkg::FN_WATER: return d.water_alarm;
      tiofm_pkg::FN_BRAKE: return d.brake_ctrl;
      default: return 1'b0;
    endcase
  endfunction

  // Source normalised so 10000 is full scale
  function automatic logic signed [31:0] fn_src(input logic [15:0] sel,
      input tiofm_pkg::tiofm_drv_type d,
      input logic signed [15:0] a1, input logic signed [15:0] a2);
    unique case (sel)
      16'h0001: return 32'(d.set_speed) * 10;
      16'h0002: return 32'(d.out_speed) * 10;
      16'h0003: return 32'(d.out_freq) * 10;
      16'h0004: return 32'(d.out_current) * 5;
      16'h0005: return 32'(d.out_voltage) * 10;
      16'h0006: return 32'(d.dc_bus);
      16'h0007: return (32'(d.torque_cmd) * 10) / 3;
      16'h0008: return 32'(a1);
      16'h0009: return 32'(a2);
      16'h000a: return 32'(d.ain_three);
      16'h000b: return 32'(d.pulse_freq) * 10;
      16'h000c: return 32'(d.torque) * 10;
      default: return 32'sd0;
    endcase
  endfunction

  // ==========================================================
  // Parameter store
  logic [15:0] par_reg [0:tiofm_pkg::NREG-1];
  logic [5:0] wr_dec;
  logic [5:0] rd_dec;
  assign wr_dec = fn_decode(PAR_ADDR);
  assign rd_dec = wr_dec;

  // Writes land at once; unmapped addresses are dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < tiofm_pkg::NREG; i++) begin
        par_reg[i] <= fn_rst(5'(i));
      end
    end else if (CE && PAR_WE && wr_dec[5]) begin
      par_reg[wr_dec[4:0]] <= PAR_WDATA;
    end
  end

  // Read data one cycle after the address, zero when unmapped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAR_RDATA <= 16'h0000;
    end else if (CE) begin
      PAR_RDATA <= rd_dec[5] ? par_reg[rd_dec[4:0]] : 16'h0000;
    end
  end

  // ==========================================================
  // Digital functions
  logic c_rly1;
  logic c_rly2;
  logic c_flt;
  assign c_rly1 = fn_cond(par_reg[tiofm_pkg::R_RLY1_FN], DRV,
    par_reg[tiofm_pkg::R_COMM][0], par_reg[tiofm_pkg::R_SPD_LV1],
    par_reg[tiofm_pkg::R_SPD_LV2], par_reg[tiofm_pkg::R_SPD_BAND],
    par_reg[tiofm_pkg::R_TQ_SGN], par_reg[tiofm_pkg::R_TQ_ABS],
    par_reg[tiofm_pkg::R_OL_LV]);
  assign c_rly2 = fn_cond(par_reg[tiofm_pkg::R_RLY2_FN], DRV,
    par_reg[tiofm_pkg::R_COMM][0], par_reg[tiofm_pkg::R_SPD_LV1],
    par_reg[tiofm_pkg::R_SPD_LV2], par_reg[tiofm_pkg::R_SPD_BAND],
    par_reg[tiofm_pkg::R_TQ_SGN], par_reg[tiofm_pkg::R_TQ_ABS],
    par_reg[tiofm_pkg::R_OL_LV]);
  assign c_flt = fn_cond(par_reg[tiofm_pkg::R_FLT_FN], DRV,
    par_reg[tiofm_pkg::R_COMM][0], par_reg[tiofm_pkg::R_SPD_LV1],
    par_reg[tiofm_pkg::R_SPD_LV2], par_reg[tiofm_pkg::R_SPD_BAND],
    par_reg[tiofm_pkg::R_TQ_SGN], par_reg[tiofm_pkg::R_TQ_ABS],
    par_reg[tiofm_pkg::R_OL_LV]);

  // Fault relay has no delay and follows its condition
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_CHANGEOVER_RELAY <= 1'b0;
    end else if (CE) begin
      FAULT_CHANGEOVER_RELAY <= c_flt;
    end
  end

  // Relay delay counters in ticks; a dropped condition restarts the wait
  logic [31:0] dly1_reg;
  logic [31:0] dly2_reg;
  logic [31:0] lim1;
  logic [31:0] lim2;
  assign lim1 = 32'(par_reg[tiofm_pkg::R_RLY1_DLY]) * 32'(tiofm_pkg::TICKS_PER_DELAY);
  assign lim2 = 32'(par_reg[tiofm_pkg::R_RLY2_DLY]) * 32'(tiofm_pkg::TICKS_PER_DELAY);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly1_reg <= 32'h0000_0000;
      RELAY_OUTPUT_ONE <= 1'b0;
    end else if (CE) begin
      if (!c_rly1) begin
        dly1_reg <= 32'h0000_0000;
        RELAY_OUTPUT_ONE <= 1'b0;
      end else if (dly1_reg >= lim1) begin
        RELAY_OUTPUT_ONE <= 1'b1;
      end else if (TICK) begin
        dly1_reg <= dly1_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly2_reg <= 32'h0000_0000;
      RELAY_OUTPUT_TWO <= 1'b0;
    end else if (CE) begin
      if (!c_rly2) begin
        dly2_reg <= 32'h0000_0000;
        RELAY_OUTPUT_TWO <= 1'b0;
      end else if (dly2_reg >= lim2) begin
        RELAY_OUTPUT_TWO <= 1'b1;
      end else if (TICK) begin
        dly2_reg <= dly2_reg + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // Analog inputs: range, dead band, scale, filter
  logic signed [31:0] ai1_cond;
  logic signed [31:0] ai2_cond;
  logic signed [31:0] ai1_scl;
  logic signed [31:0] ai2_scl;
  assign ai1_cond = fn_ain(AIN_ONE, par_reg[tiofm_pkg::R_AI1_RNG][1:0], 1'b0,
    par_reg[tiofm_pkg::R_AI_MIN]);
  assign ai2_cond = fn_ain(AIN_TWO, par_reg[tiofm_pkg::R_AI2_RNG][1:0], 1'b1,
    par_reg[tiofm_pkg::R_AI_MIN]);
  // Unipolar inputs saturate at zero, the bipolar one at minus full scale
  assign ai1_scl = fn_scale(ai1_cond, par_reg[tiofm_pkg::R_AI1_GAIN],
    par_reg[tiofm_pkg::R_AI1_BIAS], 0, tiofm_pkg::FULL_MV);
  assign ai2_scl = fn_scale(ai2_cond, par_reg[tiofm_pkg::R_AI2_GAIN],
    par_reg[tiofm_pkg::R_AI2_BIAS],
    (par_reg[tiofm_pkg::R_AI2_RNG][1:0] == tiofm_pkg::RNG_BIPOLAR) ?
    -tiofm_pkg::FULL_MV : 0, tiofm_pkg::FULL_MV);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      AIN_ONE_VAL <= 16'sh0000;
      AIN_TWO_VAL <= 16'sh0000;
    end else if (CE && TICK) begin
      AIN_ONE_VAL <= 16'(fn_filt(32'(AIN_ONE_VAL), ai1_scl,
        par_reg[tiofm_pkg::R_AI1_FILT]));
      AIN_TWO_VAL <= 16'(fn_filt(32'(AIN_TWO_VAL), ai2_scl,
        par_reg[tiofm_pkg::R_AI2_FILT]));
    end
  end

  // ==========================================================
  // Analog outputs: source, scale, filter, range
  logic signed [31:0] ao1_scl;
  logic signed [31:0] ao2_scl;
  logic signed [15:0] ao1_reg;
  logic signed [15:0] ao2_reg;
  logic signed [15:0] ao1_next;
  logic signed [15:0] ao2_next;
  assign ao1_scl = fn_scale(fn_src(par_reg[tiofm_pkg::R_AO1_SRC], DRV,
    AIN_ONE_VAL, AIN_TWO_VAL), par_reg[tiofm_pkg::R_AO1_GAIN],
    par_reg[tiofm_pkg::R_AO1_BIAS], 0, tiofm_pkg::FULL_MV);
  assign ao2_scl = fn_scale(fn_src(par_reg[tiofm_pkg::R_AO2_SRC], DRV,
    AIN_ONE_VAL, AIN_TWO_VAL), par_reg[tiofm_pkg::R_AO2_GAIN],
    par_reg[tiofm_pkg::R_AO2_BIAS], 0, tiofm_pkg::FULL_MV);
  assign ao1_next = 16'(fn_filt(32'(ao1_reg), ao1_scl, par_reg[tiofm_pkg::R_AO1_FILT]));
  assign ao2_next = 16'(fn_filt(32'(ao2_reg), ao2_scl, par_reg[tiofm_pkg::R_AO2_FILT]));

  // Filter state and pin value are both flops, so the pin lags one tick
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ao1_reg <= 16'sh0000;
      ao2_reg <= 16'sh0000;
      ANALOG_OUTPUT_ONE <= 16'h0000;
      ANALOG_OUTPUT_TWO <= 16'h0000;
    end else if (CE && TICK) begin
      ao1_reg <= ao1_next;
      ao2_reg <= ao2_next;
      // Current mode maps 0..10 V onto 4..20 mA in uA
      if (par_reg[tiofm_pkg::R_AO1_RNG][1:0] == tiofm_pkg::RNG_CURRENT) begin
        ANALOG_OUTPUT_ONE <= 16'(tiofm_pkg::LOOP_MA_LO + (32'(ao1_reg) * 8) / 5);
      end else begin
        ANALOG_OUTPUT_ONE <= 16'(ao1_reg);
      end
      ANALOG_OUTPUT_TWO <= 16'(ao2_reg);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_run;
    CE && par_reg[tiofm_pkg::R_FLT_FN] == tiofm_pkg::FN_RUN
      |=> FAULT_CHANGEOVER_RELAY == $past(DRV.running || DRV.dc_brake);
  endproperty
  a_run: assert property (p_run) else $error("run output wrong");

  property p_comm;
    CE && par_reg[tiofm_pkg::R_FLT_FN] == tiofm_pkg::FN_COMM
      |=> FAULT_CHANGEOVER_RELAY == $past(par_reg[tiofm_pkg::R_COMM][0]);
  endproperty
  a_comm: assert property (p_comm) else $error("comm output wrong");

  property p_water;
    CE && par_reg[tiofm_pkg::R_FLT_FN] == tiofm_pkg::FN_WATER
      |=> FAULT_CHANGEOVER_RELAY == $past(DRV.water_alarm);
  endproperty
  a_water: assert property (p_water) else $error("water output wrong");

  property p_brake;
    CE && par_reg[tiofm_pkg::R_FLT_FN] == tiofm_pkg::FN_BRAKE
      |=> FAULT_CHANGEOVER_RELAY == $past(DRV.brake_ctrl);
  endproperty
  a_brake: assert property (p_brake) else $error("brake output wrong");

  property p_delay;
    $rose(RELAY_OUTPUT_ONE) |-> $past(dly1_reg >= lim1 && c_rly1);
  endproperty
  a_delay: assert property (p_delay) else $error("relay early");

  property p_drop;
    CE && !c_rly2 |=> !RELAY_OUTPUT_TWO && dly2_reg == 32'h0000_0000;
  endproperty
  a_drop: assert property (p_drop) else $error("relay not released");

  property p_unipolar;
    par_reg[tiofm_pkg::R_AI1_RNG][1:0] == tiofm_pkg::RNG_VOLT && AIN_ONE < 0
      |-> ai1_cond == 0;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("negative not clamped");

  property p_dead;
    fn_abs(32'(AIN_TWO)) < 32'(par_reg[tiofm_pkg::R_AI_MIN]) |-> ai2_cond == 0;
  endproperty
  a_dead: assert property (p_dead) else $error("dead band broken");

  property p_nofilt;
    CE && TICK && par_reg[tiofm_pkg::R_AI1_FILT] == 16'h0000
      |=> 32'(AIN_ONE_VAL) == $past(ai1_scl);
  endproperty
  a_nofilt: assert property (p_nofilt) else $error("bypass filter wrong");

  property p_loop;
    CE && TICK && par_reg[tiofm_pkg::R_AO1_RNG][1:0] == tiofm_pkg::RNG_CURRENT
      |=> ANALOG_OUTPUT_ONE >= 16'h0fa0 && ANALOG_OUTPUT_ONE <= 16'h4e20;
  endproperty
  a_loop: assert property (p_loop) else $error("loop current out of range");

  c_relay_on: cover property (CE && c_rly1 ##[1:20] RELAY_OUTPUT_ONE);
  c_fault: cover property ($rose(FAULT_CHANGEOVER_RELAY));
  c_write: cover property (PAR_WE && wr_dec[5] && CE);
  c_bipolar: cover property (AIN_TWO_VAL < 0);
endmodule

// ===== test/tiofm_field.sv
// Purpose: Field wiring model, analog signal sources facing the terminals
// Assumes: Sources settle within one clock
// Notes: Input two sees the inverted source, so one sweep puts both polarities on the inputs
module tiofm_field (
  input wire logic CLK,
  input wire logic signed [15:0] SRC_MV,
  output logic signed [15:0] AIN_ONE,
  output logic signed [15:0] AIN_TWO
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Sources follow the requested level on each clock
  always_ff @(posedge CLK) begin
    AIN_ONE <= SRC_MV;
    AIN_TWO <= -SRC_MV;
  end
endmodule

// ===== test/tb_terminal_io_function_mapper.sv
// Purpose: Self-checking bench for relay mapping and analog input conditioning
// Assumes: TICK pulses every other clock, CE low only in the freeze step
// Notes: Analog outputs are compared once, after the input sweep has settled
module tb_terminal_io_function_mapper;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0, RST_N = 1'b0, TICK = 1'b0, tick_en = 1'b0, PAR_WE = 1'b0;
  logic ce = 1'b1;
  logic [15:0] PAR_ADDR = 16'h0000, PAR_WDATA = 16'h0000, PAR_RDATA, rv;
  logic signed [15:0] src = 16'sh0000, AIN_ONE, AIN_TWO, AV1, AV2, e, e2;
  logic R1, R2, RF;
  logic [15:0] AO1, AO2;
  logic [15:0] fn [4] = '{16'h0023, 16'h0024, 16'h0025, 16'h0028};
  tiofm_pkg::tiofm_drv_type drv = '0, d;
  int miscompares = 0, check_count = 0, n, x, g, b;
  tiofm_top u_dut (.CLK(CLK), .RST_N(RST_N), .CE(ce), .TICK(TICK), .DRV(drv),
    .AIN_ONE(AIN_ONE), .AIN_TWO(AIN_TWO), .PAR_WE(PAR_WE), .PAR_ADDR(PAR_ADDR),
    .PAR_WDATA(PAR_WDATA), .PAR_RDATA(PAR_RDATA), .RELAY_OUTPUT_ONE(R1),
    .RELAY_OUTPUT_TWO(R2), .FAULT_CHANGEOVER_RELAY(RF), .AIN_ONE_VAL(AV1),
    .AIN_TWO_VAL(AV2), .ANALOG_OUTPUT_ONE(AO1), .ANALOG_OUTPUT_TWO(AO2));
  tiofm_field u_field (.CLK(CLK), .SRC_MV(src), .AIN_ONE(AIN_ONE), .AIN_TWO(AIN_TWO));
  // ==========================================================
  // Clock and a one-cycle tick every other edge
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK) TICK <= tick_en & ~TICK;
  // ==========================================================
  // Compare, bus and expectation helpers
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic chk_bit(input logic e, input logic a);
    chk({15'h0000, e}, {15'h0000, a});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge CLK);
    PAR_WE <= 1'b1;
    PAR_ADDR <= a;
    PAR_WDATA <= v;
    @(posedge CLK);
    PAR_WE <= 1'b0;
  endtask
  // Read data lags the address by one cycle
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(posedge CLK);
    PAR_ADDR <= a;
    repeat (2) @(posedge CLK);
    #1;
    chk(e, PAR_RDATA);
  endtask
  task automatic setd(input tiofm_pkg::tiofm_drv_type v);
    @(posedge CLK);
    drv <= v;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // 40 mV dead band, negatives clamped when unipolar, then gain, bias and saturation
  function automatic logic [15:0] exp_ain(input int v, input int gn, input int bs,
      input int lo);
    int y;
    y = ((v < 40 && lo == 0) || (v > -40 && v < 40)) ? 0 : v;
    y = y * gn / 1000 + bs * 10;
    y = (y < lo) ? lo : ((y > 10000) ? 10000 : y);
    return 16'(y);
  endfunction
  task automatic stop_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(81));
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    tick_en <= 1'b1;
    rd_chk(16'h0108, 16'h01f4);
    rd_chk(16'h0109, 16'h0011);
    rd_chk(16'h0113, 16'h0003);
    rd_chk(16'h010b, 16'h03e8);
    rd_chk(16'h0110, 16'h0064);
    rd_chk(16'h0101, 16'h0000);
    rd_chk(16'h0104, 16'h0000);
    wr(16'h0200, 16'h1234);
    rd_chk(16'h0200, 16'h0000);
    // Default fault relay code follows the fault flag
    d = '0;
    d.fault = 1'b1;
    setd(d);
    chk_bit(1'b1, RF);
    // Codes 35, 36, 37 and 40 on relay two and the fault relay, raised then dropped
    for (n = 0; n < 4; n++) begin
      wr(16'h011d, fn[n]);
      wr(16'h0109, fn[n]);
      d = '0;
      d.dc_brake = (n == 0);
      d.water_alarm = (n == 2);
      d.brake_ctrl = (n == 3);
      wr(16'h600b, 16'(n == 1));
      setd(d);
      chk_bit(1'b1, R2);
      chk_bit(1'b1, RF);
      wr(16'h600b, 16'h0000);
      setd('0);
      chk_bit(1'b0, R2);
      chk_bit(1'b0, RF);
    end
    // Torque thresholds on the fault relay, equality forced once for each of the two codes
    for (n = 0; n < 8; n++) begin
      g = $urandom_range(1000);
      x = (n == 0 || n == 4) ? g : int'($urandom_range(2000)) - 1000;
      wr(16'h0109, (n < 4) ? 16'h0009 : 16'h000a);
      wr((n < 4) ? 16'h0106 : 16'h0107, 16'(g));
      d = '0;
      d.torque = 16'(x);
      setd(d);
      chk_bit((n < 4) ? (x >= g) : ((x < 0 ? -x : x) >= g), RF);
    end
    // Relay one waits 0.1 s, 100 ticks, after running starts
    wr(16'h0101, 16'h0001);
    d = '0;
    d.running = 1'b1;
    setd(d);
    chk_bit(1'b0, R1);
    x = 0;
    for (n = 0; n < 600 && R1 !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
      if (TICK === 1'b1) x++;
    end
    chk_bit(1'b1, R1);
    chk_bit(1'b1, x >= 98 && x <= 101);
    if (R1 !== 1'b1) stop_test();
    // Clock enable low freezes the relay although running has stopped
    @(posedge CLK);
    ce <= 1'b0;
    setd('0);
    chk_bit(1'b1, R1);
    @(posedge CLK);
    ce <= 1'b1;
    setd('0);
    chk_bit(1'b0, R1);
    // Both inputs unfiltered, input two bipolar, input one with random gain and bias
    wr(16'h0110, 16'h0000);
    wr(16'h0111, 16'h0000);
    wr(16'h010d, 16'h0001);
    for (n = 0; n < 12; n++) begin
      x = (n == 0) ? 30 : ((n == 1) ? -500 : int'($urandom_range(14000)) - 2000);
      g = $urandom_range(2000);
      b = int'($urandom_range(600)) - 300;
      wr(16'h010b, 16'(g));
      wr(16'h010c, 16'(b));
      @(posedge CLK);
      src <= 16'(x);
      repeat (6) @(posedge CLK);
      #1;
      e = exp_ain(x, g, b, 0);
      e2 = exp_ain(-x, 1000, 0, -10000);
      chk(e, AV1);
      chk(e2, AV2);
    end
    // Outputs fed from both inputs, unfiltered, output one as a loop current
    wr(16'h0113, 16'h0008);
    wr(16'h0117, 16'h0000);
    wr(16'h0114, 16'h0002);
    wr(16'h0118, 16'h0009);
    wr(16'h011b, 16'h0000);
    repeat (6) @(posedge CLK);
    #1;
    chk(16'(4000 + int'(e) * 8 / 5), AO1);
    chk((e2 < 0) ? 16'h0000 : e2, AO2);
    stop_test();
  end
endmodule
